// file: rtl/sld_ctrl.sv
// Purpose: Control, reset and frame timing for an on-chip segment display driver.
// Assumes: One clock pclk; sub_clock_tick marks each sub clock edge; inputs synchronous.
// Notes: Drives per-line level codes; the analog network turns codes into voltages.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`default_nettype none

module sld_ctrl #(
   parameter int NUM_SEGMENTS = sld_pkg::SLD_NUM_SEGMENTS
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Chip state
   input wire logic sleep_active,
   input wire logic chip_reset_active,
   input wire logic wdt_reset_in_low_power,
   input wire logic sub_clock_tick,
   // Analog controls and line drive
   output sld_pkg::sld_analog_type analog_ctrl,
   output logic [sld_pkg::SLD_NUM_COMMONS-1:0] com_release,
   output logic [2*sld_pkg::SLD_NUM_COMMONS-1:0] com_level,
   output logic [2*NUM_SEGMENTS-1:0] seg_level,
   output logic lines_float
);

   localparam int NC = sld_pkg::SLD_NUM_COMMONS;
   // Level codes of the third-bias ladder.
   localparam logic [1:0] LVL_GND = 2'h0;
   localparam logic [1:0] LVL_THIRD = 2'h1;
   localparam logic [1:0] LVL_TWO_THIRDS = 2'h2;
   localparam logic [1:0] LVL_FULL = 2'h3;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] control_ff;
   logic [7:0] power_ff;
   logic [NC-1:0] pixel_mem [NUM_SEGMENTS];
   logic [2:0] div_ff;
   logic [2:0] slot_ff;
   logic phase_ff;
   logic frame_pol_ff;
   logic frame_tick;
   logic display_reset;
   logic chip_reset;
   logic quarter;
   logic [2:0] last_slot;
   logic wr_en;
   logic rd_en;
   logic [6:0] seg_index;
   logic [11:0] mem_off;
   logic mem_hit;

   // Returns the drive level of one line from its polarity pattern.
   function automatic logic [1:0] pick_level(input logic selected, input logic is_com,
                                             input logic pol);
      logic [1:0] lvl;
      lvl = LVL_GND;
      if (is_com) begin
         if (selected) begin
            lvl = pol ? LVL_FULL : LVL_GND;
         end else begin
            lvl = pol ? LVL_THIRD : LVL_TWO_THIRDS;
         end
      end else begin
         if (selected) begin
            lvl = pol ? LVL_GND : LVL_FULL;
         end else begin
            lvl = pol ? LVL_TWO_THIRDS : LVL_THIRD;
         end
      end
      return lvl;
   endfunction : pick_level

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   // Zero-wait slave: every access completes in its first access cycle.
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !pwrite;
   // The window is bounded on the full offset so that high addresses cannot alias.
   assign mem_off = paddr - sld_pkg::SLD_DISPLAY_MEMORY_OFFSET;
   assign seg_index = mem_off[8:2];
   assign mem_hit = (paddr >= sld_pkg::SLD_DISPLAY_MEMORY_OFFSET) &&
                    (mem_off < 12'(4 * NUM_SEGMENTS)) && (paddr[1:0] == 2'h0);
   assign pslverr = psel && penable &&
                    !(mem_hit || paddr == sld_pkg::SLD_DISPLAY_CONTROL_OFFSET ||
                      paddr == sld_pkg::SLD_DISPLAY_POWER_CONTROL_OFFSET ||
                      paddr == sld_pkg::SLD_STATUS_OFFSET);

   // Control register; reserved bits are never stored.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_ff <= sld_pkg::SLD_CONTROL_RESET;
      end else if (wr_en && pstrb[0] && paddr == sld_pkg::SLD_DISPLAY_CONTROL_OFFSET) begin
         control_ff <= pwdata[7:0] & sld_pkg::SLD_CONTROL_MASK;
      end
   end

   // Power control register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_ff <= sld_pkg::SLD_POWER_RESET;
      end else if (wr_en && pstrb[0] && paddr == sld_pkg::SLD_DISPLAY_POWER_CONTROL_OFFSET) begin
         power_ff <= pwdata[7:0] & sld_pkg::SLD_POWER_MASK;
      end
   end

   // Display memory is not reset: its power-on content is left to software.
   always_ff @(posedge pclk) begin
      if (wr_en && pstrb[0] && mem_hit) begin
         pixel_mem[seg_index[5:0]] <= pwdata[NC-1:0];
      end
   end

   // Read data is registered; prdata updates in the setup cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en && !penable) begin
         if (paddr == sld_pkg::SLD_DISPLAY_CONTROL_OFFSET) begin
            prdata <= {24'h00_0000, control_ff};
         end else if (paddr == sld_pkg::SLD_DISPLAY_POWER_CONTROL_OFFSET) begin
            prdata <= {24'h00_0000, power_ff};
         end else if (paddr == sld_pkg::SLD_STATUS_OFFSET) begin
            prdata <= {29'h0, slot_ff};
         end else if (mem_hit) begin
            // Commons 4 and 5 read zero in quarter duty.
            prdata <= {26'h0, pixel_mem[seg_index[5:0]] &
                       (quarter ? 6'h0F : 6'h3F)};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // ---------------------------------------------------------------
   // Reset status
   // ---------------------------------------------------------------
   // A watchdog reset raised while idle or asleep does not float the lines.
   assign chip_reset = chip_reset_active && !wdt_reset_in_low_power;
   // Sleep overrides the enable; the enable acts only when awake.
   assign display_reset = !control_ff[sld_pkg::SLD_ENABLE_POS] || sleep_active;
   assign lines_float = chip_reset;
   assign quarter = !power_ff[sld_pkg::SLD_DUTY_POS];
   assign last_slot = quarter ? 3'd3 : 3'd5;
   assign com_release = quarter ? 6'b110000 : 6'b000000;

   // Analog controls.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_ctrl <= '0;
      end else begin
         analog_ctrl.display_reset <= display_reset || chip_reset;
         analog_ctrl.bias_path_on <= !(display_reset || chip_reset);
         analog_ctrl.pump_enable <= power_ff[sld_pkg::SLD_SUPPLY_POS] &&
            !(display_reset || chip_reset);
         // The voltage code means nothing while the external pin supplies power.
         analog_ctrl.pump_voltage_code <= power_ff[sld_pkg::SLD_SUPPLY_POS] ?
            power_ff[sld_pkg::SLD_PUMP_LO_POS +: 2] : 2'h0;
         analog_ctrl.bias_current_code <= control_ff[sld_pkg::SLD_BIAS_LO_POS +: 2];
      end
   end

   // ---------------------------------------------------------------
   // Frame timing
   // ---------------------------------------------------------------
   assign frame_tick = sub_clock_tick && (div_ff == 3'(sld_pkg::SLD_SUB_DIVIDE - 1));

   // Divides the sub clock by eight.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= 3'h0;
      end else if (display_reset || chip_reset) begin
         div_ff <= 3'h0;
      end else if (sub_clock_tick) begin
         div_ff <= div_ff + 3'h1;
      end
   end

   // Slot counter with half-slot phase; type A flips mid-slot, type B per frame.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_ff <= 3'h0;
         phase_ff <= 1'b0;
         frame_pol_ff <= 1'b0;
      end else if (display_reset || chip_reset) begin
         slot_ff <= 3'h0;
         phase_ff <= 1'b0;
         frame_pol_ff <= 1'b0;
      end else if (frame_tick) begin
         phase_ff <= !phase_ff;
         if (phase_ff) begin
            if (slot_ff >= last_slot) begin
               slot_ff <= 3'h0;
               frame_pol_ff <= !frame_pol_ff;
            end else begin
               slot_ff <= slot_ff + 3'h1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Line levels
   // ---------------------------------------------------------------
   // Levels come from flip-flops so that lines never glitch between codes.
   always_ff @(posedge pclk or negedge presetn) begin
      logic pol;
      pol = 1'b0;
      if (!presetn) begin
         com_level <= '0;
         seg_level <= '0;
      end else if (display_reset || chip_reset) begin
         com_level <= '0;
         seg_level <= '0;
      end else begin
         pol = control_ff[sld_pkg::SLD_TYPE_POS] ? frame_pol_ff : phase_ff;
         for (int c = 0; c < NC; c++) begin
            com_level[2*c +: 2] <= (quarter && c >= 4) ? LVL_GND :
               pick_level(slot_ff == 3'(c), 1'b1, pol);
         end
         for (int s = 0; s < NUM_SEGMENTS; s++) begin
            seg_level[2*s +: 2] <= pick_level(pixel_mem[s][slot_ff], 1'b0, pol);
         end
      end
   end

endmodule : sld_ctrl

`default_nettype wire

// file: rtl/sld_pkg.sv
// Purpose: Shared constants and types for the segment display driver control block.
// Assumes: APB slave with 32-bit data, 200 MHz pclk.
// Notes: Control and power registers are 8 bits wide, held in the low byte of each word.
`default_nettype none

package sld_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [11:0] SLD_DISPLAY_CONTROL_OFFSET = 12'h000;
   localparam logic [11:0] SLD_DISPLAY_POWER_CONTROL_OFFSET = 12'h004;
   localparam logic [11:0] SLD_DISPLAY_MEMORY_OFFSET = 12'h100;
   localparam logic [11:0] SLD_STATUS_OFFSET = 12'h008;
   localparam logic [7:0] SLD_CONTROL_RESET = 8'h00;
   localparam logic [7:0] SLD_POWER_RESET = 8'h00;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int SLD_ENABLE_POS = 0;
   localparam int SLD_BIAS_LO_POS = 1;
   localparam int SLD_TYPE_POS = 7;
   localparam int SLD_PUMP_LO_POS = 0;
   localparam int SLD_SUPPLY_POS = 3;
   localparam int SLD_DUTY_POS = 4;
   localparam logic [7:0] SLD_CONTROL_MASK = 8'h87;
   localparam logic [7:0] SLD_POWER_MASK = 8'h1B;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int SLD_SUB_DIVIDE = 8;
   localparam int SLD_NUM_COMMONS = 6;
   localparam int SLD_NUM_SEGMENTS = 38;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SLD_PWR_RUN, SLD_PWR_IDLE_FAST, SLD_PWR_SLEEP, SLD_PWR_OTHER
   } sld_pwr_type;

   typedef struct packed {
      logic wave_type_b;
      logic [1:0] bias_current_code;
      logic display_enable_bit;
      logic duty_select_bit;
      logic supply_select_bit;
      logic [1:0] pump_voltage_code;
   } sld_cfg_type;

   typedef struct packed {
      logic display_reset;
      logic bias_path_on;
      logic pump_enable;
      logic [1:0] pump_voltage_code;
      logic [1:0] bias_current_code;
   } sld_analog_type;

endpackage : sld_pkg

`default_nettype wire

// file: testbench/sld_ctrl_monitor.sv
// Purpose: Port assertions for the segment display control block.
// Assumes: One clock domain, presetn asynchronous and active low.
// Notes: Line levels are registered, so line checks allow one edge.
`default_nettype none
module sld_ctrl_monitor #(
   parameter int NUM_SEGMENTS = sld_pkg::SLD_NUM_SEGMENTS
) (
   // Clock, reset and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Chip state and line drive
   input wire logic sleep_active,
   input wire logic chip_reset_active,
   input wire logic wdt_reset_in_low_power,
   input wire sld_pkg::sld_analog_type analog_ctrl,
   input wire logic [sld_pkg::SLD_NUM_COMMONS-1:0] com_release,
   input wire logic [2*sld_pkg::SLD_NUM_COMMONS-1:0] com_level,
   input wire logic [2*NUM_SEGMENTS-1:0] seg_level,
   input wire logic lines_float
);
   timeunit 1ns;
   timeprecision 100ps;
   // -----------------------------------------------------------------
   // Properties
   // -----------------------------------------------------------------
   // Everything here belongs to pclk and is quiet while reset is held.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   chk_float_chip: assert property (
      chip_reset_active && !wdt_reset_in_low_power |-> lines_float)
      else $error("lines not floating in chip reset");
   chk_wdt_excluded: assert property (
      chip_reset_active && wdt_reset_in_low_power |-> !lines_float)
      else $error("low power watchdog reset floated the lines");
   chk_sleep_off: assert property (sleep_active |=> analog_ctrl.display_reset)
      else $error("display not reset in sleep");
   chk_bias_path: assert property (
      analog_ctrl.display_reset |-> !analog_ctrl.bias_path_on)
      else $error("bias path on while display off");
   chk_pump_reset: assert property (
      analog_ctrl.display_reset |-> !analog_ctrl.pump_enable)
      else $error("pump running while display off");
   chk_lines_low: assert property (
      analog_ctrl.display_reset [*2] |-> com_level == '0 && seg_level == '0)
      else $error("lines not low during display reset");
   chk_float_low: assert property (lines_float |=> com_level == '0)
      else $error("levels kept after chip reset");
   chk_quarter_free: assert property (
      com_release[3:0] == 4'h0 && com_release[5] == com_release[4])
      else $error("wrong commons released");
   chk_err_read: assert property (
      psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
      else $error("refused read returned data");
endmodule : sld_ctrl_monitor
bind sld_ctrl sld_ctrl_monitor #(.NUM_SEGMENTS(NUM_SEGMENTS)) u_mon (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
   .pslverr(pslverr), .sleep_active(sleep_active), .chip_reset_active(chip_reset_active),
   .wdt_reset_in_low_power(wdt_reset_in_low_power), .analog_ctrl(analog_ctrl),
   .com_release(com_release), .com_level(com_level), .seg_level(seg_level),
   .lines_float(lines_float));
`default_nettype wire

// file: testbench/sld_ctrl_tb.sv
// Purpose: Self-checking bench for the segment display control block.
// Assumes: APB master with zero or more wait states; 200 MHz pclk.
// Notes: Outputs are sampled at an edge, so they hold pre-edge values.
`default_nettype none
module sld_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   // -----------------------------------------------------------------
   // Signals and design
   // -----------------------------------------------------------------
   logic pclk, presetn, psel, penable, pwrite, sleep, crst, wdt, tick, clr, err;
   logic pready, pslverr, lines_float;
   logic [1:0] div;
   logic [3:0] pstrb;
   logic [11:0] paddr, com_level;
   logic [31:0] pwdata, prdata, q;
   logic [5:0] com_release;
   logic [75:0] seg_level;
   sld_pkg::sld_analog_type ana;
   int n_fail, samples_checked, flips, flips_a;
   sld_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sleep_active(sleep), .chip_reset_active(crst),
      .wdt_reset_in_low_power(wdt), .sub_clock_tick(tick), .analog_ctrl(ana),
      .com_release(com_release), .com_level(com_level), .seg_level(seg_level),
      .lines_float(lines_float));
   sld_panel_model panel (.pclk(pclk), .clear(clr), .com_level(com_level),
      .lines_float(lines_float), .flips(flips));
   // Clock, and a sub clock tick every fourth cycle.
   initial begin
      pclk = 1'h0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      div <= div + 2'h1;
      tick <= (div == 2'h3);
   end
   // One APB transfer; the wait is bounded so a dead slave cannot hang the run.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      q = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // Two idle edges: registered outputs launched by the write have settled.
      @(posedge pclk);
      @(posedge pclk);
      if (n >= 20) begin
         n_fail++;
         $display("unexpected at %0t: bus transfer timed out", $time);
         conclude();
      end
   endtask : xfer
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : cmp
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'h0, a, 32'h0);
      cmp(q, exp);
   endtask : rd
   task automatic conclude();
      $display("compares %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude
   // -----------------------------------------------------------------
   // Tests
   // -----------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, sleep, crst, wdt, tick, clr} = 9'h000;
      {paddr, pwdata, pstrb, div} = 50'h0_0000_0000_003C;
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      rd(12'h000, 32'h0);
      rd(12'h004, 32'h0);
      xfer(1'h1, 12'h000, 32'hFF);
      rd(12'h000, 32'h87);
      xfer(1'h1, 12'h004, 32'hFF);
      rd(12'h004, 32'h1B);
      xfer(1'h1, 12'h100, 32'h3F);
      xfer(1'h1, 12'h004, 32'h0);
      rd(12'h100, 32'h0F);
      cmp({30'h0, com_release[5:4]}, 32'h3);
      $display("test registers done");
      for (int c = 0; c < 4; c++) begin
         xfer(1'h1, 12'h000, 32'(2 * c + 1));
         cmp({28'h0, ana.display_reset, ana.bias_path_on, ana.bias_current_code}, 32'(4 + c));
         xfer(1'h1, 12'h004, 32'(8 + c));
         cmp({29'h0, ana.pump_enable, ana.pump_voltage_code}, 32'(4 + c));
      end
      xfer(1'h1, 12'h004, 32'h13);
      cmp({26'h0, com_release, ana.pump_enable, ana.pump_voltage_code}, 32'h0);
      $display("test analog codes done");
      sleep <= 1'h1;
      repeat (3) @(posedge pclk);
      cmp({31'h0, ana.display_reset}, 32'h1);
      sleep <= 1'h0;
      repeat (3) @(posedge pclk);
      cmp({31'h0, ana.display_reset}, 32'h0);
      crst <= 1'h1;
      repeat (3) @(posedge pclk);
      cmp({31'h0, lines_float}, 32'h1);
      wdt <= 1'h1;
      repeat (3) @(posedge pclk);
      cmp({31'h0, lines_float}, 32'h0);
      {crst, wdt} <= 2'h0;
      xfer(1'h1, 12'h000, 32'h0);
      cmp({31'h0, ana.display_reset}, 32'h1);
      xfer(1'h0, 12'h0FC, 32'h0);
      cmp({err, q[30:0]}, 32'h8000_0000);
      $display("test reset states done");
      xfer(1'h1, 12'h000, 32'h01);
      clr <= 1'h1;
      @(posedge pclk);
      clr <= 1'h0;
      repeat (2000) @(posedge pclk);
      flips_a = flips;
      xfer(1'h1, 12'h000, 32'h81);
      clr <= 1'h1;
      @(posedge pclk);
      clr <= 1'h0;
      repeat (2000) @(posedge pclk);
      cmp(32'(flips < flips_a), 32'h1);
      $display("test waveform types done");
      conclude();
   end
endmodule : sld_ctrl_tb
`default_nettype wire

// file: testbench/sld_panel_model.sv
// Purpose: Passive display glass seen from common line zero.
// Assumes: The glass only loads the lines; it never answers.
// Notes: Counts level changes so the bench can compare drive rates.
`default_nettype none
module sld_panel_model (
   // Clock and control
   input wire logic pclk,
   input wire logic clear,
   // Lines
   input wire logic [11:0] com_level,
   input wire logic lines_float,
   output var int flips
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] last_ff;
   // A floating line carries no charge, so it is not counted.
   always_ff @(posedge pclk) begin
      last_ff <= com_level[1:0];
      if (clear) begin
         flips <= 0;
      end else if (!lines_float && com_level[1:0] !== last_ff) begin
         flips <= flips + 1;
      end
   end
endmodule : sld_panel_model
`default_nettype wire
